// ### include/ipm_pkg.sv
// Constants, register map and source priorities of the posted-flag/mask block
package ipm_pkg;
    // ----------------------------------------------------------------
    // Bus and register geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int NUM_SRC = 24;
    localparam int SRC_W = 5;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FLAGS_A = 10'h0DA;
    localparam logic [9:0] IDX_FLAGS_B = 10'h0DB;
    localparam logic [9:0] IDX_FLAGS_C = 10'h0DC;
    localparam logic [9:0] IDX_SOFT_CTRL = 10'h0DE;
    localparam logic [9:0] IDX_MASK_C = 10'h0DF;
    localparam logic [9:0] IDX_MASK_A = 10'h0E0;
    localparam logic [9:0] IDX_MASK_B = 10'h0E1;
    localparam logic [9:0] IDX_VECTOR = 10'h0E2;

    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int SOFT_POST_BIT = 7;
    localparam logic [7:0] FLAGS_C_VALID = 8'h3F;
    localparam logic [7:0] MASK_C_VALID = 8'h7F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] VECTOR_NONE = 8'h00;
    localparam int VEC_SHIFT = 2;

    // Flat source index: A bits 0..7, B bits 8..15, C bits 16..23
    localparam logic [NUM_SRC-1:0] SRC_VALID = 24'h3FFFFF;

    // Priority number per flat source, index 23 down to 0
    localparam logic [NUM_SRC-1:0][SRC_W-1:0] SRC_PRIO = {
        5'h1F, 5'h1F, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10,
        5'h0F, 5'h0E, 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h08,
        5'h06, 5'h19, 5'h07, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};
    localparam logic [SRC_W-1:0] PRIO_NONE = 5'h1F;
endpackage

// ### design/ipm_flag_bank.sv
// Bank of posted interrupt flags with set-over-clear priority
`timescale 1ns/10ps
module ipm_flag_bank #(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Set and clear requests
    input wire logic [WIDTH-1:0] hw_set,
    input wire logic [WIDTH-1:0] sw_set,
    input wire logic [WIDTH-1:0] clr,
    // Flag state
    output logic [WIDTH-1:0] flags
);
    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } ipm_bank_type;

    ipm_bank_type state_reg;
    ipm_bank_type state_next;

    always_comb begin
        state_next = state_reg;
        // A set in the clearing cycle survives
        state_next.flags = (state_reg.flags & ~clr) | hw_set | sw_set;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flags;
endmodule

// ### design/ipm_prio_enc.sv
// Priority encoder over pending sources
`timescale 1ns/10ps
module ipm_prio_enc #(
    parameter int WIDTH = 24
) (
    // Pending sources
    input wire logic [WIDTH-1:0] pending,
    // Winner
    output logic found,
    output logic [ipm_pkg::SRC_W-1:0] src,
    output logic [ipm_pkg::SRC_W-1:0] prio
);
    always_comb begin
        found = 1'b0;
        src = '0;
        prio = ipm_pkg::PRIO_NONE;
        for (int i = 0; i < WIDTH; i++) begin
            // Lower priority number wins
            if (pending[i] && (ipm_pkg::SRC_PRIO[i] < prio)) begin
                found = 1'b1;
                src = ipm_pkg::SRC_W'(i);
                prio = ipm_pkg::SRC_PRIO[i];
            end
        end
    end
endmodule

// ### design/ipm_top.sv
// Interrupt posted-flag, mask and vector registers behind an APB slave
`timescale 1ns/10ps
module ipm_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ipm_pkg::ADDR_W-1:0] paddr,
    input wire logic [ipm_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ipm_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flag register A sources
    input wire logic power_fail_event,
    input wire logic external_line_0,
    input wire logic spi_tx_event,
    input wire logic spi_rx_event,
    input wire logic gpio_port0_event,
    input wire logic external_line_1,
    input wire logic sleep_timer_event,
    input wire logic gpio_port1_event,
    // Flag register B sources
    input wire logic endpoint0_event,
    input wire logic endpoint1_event,
    input wire logic endpoint2_event,
    input wire logic usb_reset_event,
    input wire logic usb_active_event,
    input wire logic ms_timer_event,
    input wire logic interval_timer_event,
    input wire logic capture0_event,
    // Flag register C sources
    input wire logic capture1_event,
    input wire logic counter_wrap_event,
    input wire logic external_line_2,
    input wire logic ps2_data_low_event,
    input wire logic gpio_port2_event,
    input wire logic gpio_port3_event,
    // CPU side
    input wire logic global_irq_gate,
    input wire logic cpu_irq_ack,
    output logic cpu_irq_req,
    output logic [7:0] cpu_irq_vector
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mask_a;
        logic [7:0] mask_b;
        logic [7:0] mask_c;
        logic soft_post_enable;
        logic [ipm_pkg::DATA_W-1:0] rdata;
        logic slverr;
        logic sel_valid;
        logic [ipm_pkg::SRC_W-1:0] sel_src;
        logic [7:0] vector;
    } ipm_top_type;

    ipm_top_type state_reg;
    ipm_top_type state_next;

    logic [ipm_pkg::NUM_SRC-1:0] hw_set;
    logic [ipm_pkg::NUM_SRC-1:0] sw_set;
    logic [ipm_pkg::NUM_SRC-1:0] clr;
    logic [ipm_pkg::NUM_SRC-1:0] flags;
    logic [ipm_pkg::NUM_SRC-1:0] mask_all;
    logic [ipm_pkg::NUM_SRC-1:0] pending;
    logic [ipm_pkg::NUM_SRC-1:0] ack_onehot;
    logic enc_found;
    logic [ipm_pkg::SRC_W-1:0] enc_src;
    logic [ipm_pkg::SRC_W-1:0] enc_prio;
    logic [9:0] reg_idx;
    logic aligned;
    logic setup_phase;
    logic write_access;
    logic [7:0] wbyte;
    logic [7:0] post_write;
    logic [7:0] clear_write;
    logic mask_write;

    // ----------------------------------------------------------------
    // Source wiring
    // ----------------------------------------------------------------
    assign hw_set = {
        2'b00,
        gpio_port3_event, gpio_port2_event, ps2_data_low_event,
        external_line_2, counter_wrap_event, capture1_event,
        capture0_event, interval_timer_event, ms_timer_event,
        usb_active_event, usb_reset_event, endpoint2_event,
        endpoint1_event, endpoint0_event,
        gpio_port1_event, sleep_timer_event, external_line_1,
        gpio_port0_event, spi_rx_event, spi_tx_event,
        external_line_0, power_fail_event};

    assign mask_all = {state_reg.mask_c, state_reg.mask_b, state_reg.mask_a};
    // Per-bit gating, one mask bit per source
    assign pending = flags & mask_all & ipm_pkg::SRC_VALID;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign reg_idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && pstrb[0];
    assign wbyte = pwdata[7:0];
    assign mask_write = write_access && aligned && (reg_idx == ipm_pkg::IDX_MASK_A ||
        reg_idx == ipm_pkg::IDX_MASK_B || reg_idx == ipm_pkg::IDX_MASK_C);

    // Zero wait states: every access phase completes
    assign pready = 1'b1;
    assign prdata = state_reg.rdata;
    assign pslverr = state_reg.slverr && psel && penable;

    // Written ones post only with posting enabled
    assign post_write = state_reg.soft_post_enable ? wbyte : 8'h00;
    // Written zeros clear only with posting disabled
    assign clear_write = state_reg.soft_post_enable ? 8'h00 : ~wbyte;

    // ----------------------------------------------------------------
    // Flag set and clear sources
    // ----------------------------------------------------------------
    always_comb begin
        sw_set = '0;
        clr = '0;
        if (write_access && aligned) begin
            case (reg_idx)
                ipm_pkg::IDX_FLAGS_A: begin
                    sw_set[7:0] = post_write;
                    clr[7:0] = clear_write;
                end
                ipm_pkg::IDX_FLAGS_B: begin
                    sw_set[15:8] = post_write;
                    clr[15:8] = clear_write;
                end
                ipm_pkg::IDX_FLAGS_C: begin
                    sw_set[23:16] = post_write & ipm_pkg::FLAGS_C_VALID;
                    clr[23:16] = clear_write & ipm_pkg::FLAGS_C_VALID;
                end
                ipm_pkg::IDX_VECTOR: begin
                    clr = pending;
                end
                default: begin
                    sw_set = '0;
                end
            endcase
        end
        // Taking an interrupt clears the source that won
        clr = clr | ack_onehot;
    end

    always_comb begin
        ack_onehot = '0;
        if (cpu_irq_ack && state_reg.sel_valid) begin
            ack_onehot[state_reg.sel_src] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    ipm_flag_bank #(
        .WIDTH(ipm_pkg::NUM_SRC)
    ) u_flags (
        .core_clk(core_clk),
        .rst(rst),
        .hw_set(hw_set),
        .sw_set(sw_set),
        .clr(clr),
        .flags(flags)
    );

    ipm_prio_enc #(
        .WIDTH(ipm_pkg::NUM_SRC)
    ) u_enc (
        .pending(pending),
        .found(enc_found),
        .src(enc_src),
        .prio(enc_prio)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // Encoder result, one cycle behind the flags
        state_next.sel_valid = enc_found;
        state_next.sel_src = enc_src;
        if (enc_found) begin
            state_next.vector = 8'(enc_prio) << ipm_pkg::VEC_SHIFT;
        end else begin
            state_next.vector = ipm_pkg::VECTOR_NONE;
        end
        // A just-taken or newly masked source must not be offered
        if (|(clr & ~hw_set & ~sw_set) || mask_write) begin
            state_next.sel_valid = 1'b0;
            state_next.vector = ipm_pkg::VECTOR_NONE;
        end

        // Register writes
        if (write_access && aligned) begin
            case (reg_idx)
                ipm_pkg::IDX_SOFT_CTRL: begin
                    state_next.soft_post_enable = wbyte[ipm_pkg::SOFT_POST_BIT];
                end
                ipm_pkg::IDX_MASK_A: begin
                    state_next.mask_a = wbyte;
                end
                ipm_pkg::IDX_MASK_B: begin
                    state_next.mask_b = wbyte;
                end
                ipm_pkg::IDX_MASK_C: begin
                    state_next.mask_c = wbyte & ipm_pkg::MASK_C_VALID;
                end
                default: begin
                    state_next.mask_a = state_reg.mask_a;
                end
            endcase
        end

        // Read data and error captured in the setup phase
        if (setup_phase) begin
            state_next.rdata = '0;
            state_next.slverr = 1'b0;
            if (!aligned) begin
                state_next.slverr = 1'b1;
            end else begin
                case (reg_idx)
                    ipm_pkg::IDX_FLAGS_A: begin
                        state_next.rdata[7:0] = flags[7:0];
                    end
                    ipm_pkg::IDX_FLAGS_B: begin
                        state_next.rdata[7:0] = flags[15:8];
                    end
                    ipm_pkg::IDX_FLAGS_C: begin
                        state_next.rdata[7:0] = flags[23:16] & ipm_pkg::FLAGS_C_VALID;
                    end
                    ipm_pkg::IDX_SOFT_CTRL: begin
                        state_next.rdata[ipm_pkg::SOFT_POST_BIT] =
                            state_reg.soft_post_enable;
                    end
                    ipm_pkg::IDX_MASK_C: begin
                        state_next.rdata[7:0] = state_reg.mask_c;
                    end
                    ipm_pkg::IDX_MASK_A: begin
                        state_next.rdata[7:0] = state_reg.mask_a;
                    end
                    ipm_pkg::IDX_MASK_B: begin
                        state_next.rdata[7:0] = state_reg.mask_b;
                    end
                    ipm_pkg::IDX_VECTOR: begin
                        state_next.rdata[7:0] = state_reg.vector;
                    end
                    default: begin
                        state_next.slverr = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // CPU outputs
    // ----------------------------------------------------------------
    assign cpu_irq_req = state_reg.sel_valid && global_irq_gate;
    assign cpu_irq_vector = state_reg.vector;
endmodule

// ### tb/ipm_top_checker.sv
// Assertion checker for the posted-flag and mask register block
`timescale 1ns/10ps
module ipm_top_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [ipm_pkg::ADDR_W-1:0] paddr,
    input wire logic [ipm_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // CPU side
    input wire logic global_irq_gate,
    input wire logic cpu_irq_ack,
    input wire logic cpu_irq_req,
    input wire logic [7:0] cpu_irq_vector
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    pready_up_a: assert property (psel |-> pready)
        else $error("pready low in a transfer");
    rd_upper_zero_a: assert property (psel && penable |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    err_hole_a: assert property (psel && penable && paddr == 12'h374 |-> pslverr)
        else $error("unmapped access not refused");
    err_unaligned_a: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
    req_gate_a: assert property (!global_irq_gate |-> !cpu_irq_req)
        else $error("request while gate closed");
    req_vector_a: assert property (cpu_irq_req |-> cpu_irq_vector[1:0] == 2'b00 &&
        cpu_irq_vector inside {[8'h04:8'h64]})
        else $error("request with bad vector");
    take_drop_a: assert property (cpu_irq_req && cpu_irq_ack |=> !cpu_irq_req)
        else $error("request held after take");
    reset_clear_a: assert property ($fell(rst) |-> !cpu_irq_req &&
        cpu_irq_vector == 8'h00 && !pslverr)
        else $error("outputs not cleared by reset");
    cover property (cpu_irq_req && cpu_irq_ack);
    cover property (pslverr);
    cover property ($rose(cpu_irq_req));
    cover property (psel && penable && paddr[1:0] != 2'b00 && pslverr);
endmodule

bind ipm_top ipm_top_checker i_ipm_top_checker (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_gate(global_irq_gate),
    .cpu_irq_ack(cpu_irq_ack), .cpu_irq_req(cpu_irq_req), .cpu_irq_vector(cpu_irq_vector)
);

// ### tb/ipm_cpu_model.sv
// CPU core model that takes offered interrupts after a set delay
`timescale 1ns/10ps
module ipm_cpu_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench controls
    input wire logic take_en,
    input wire logic [3:0] delay,
    // Controller side
    input wire logic cpu_irq_req,
    input wire logic [7:0] cpu_irq_vector,
    output logic cpu_irq_ack,
    output logic [7:0] taken_vec
);
    int wait_cnt;
    always @(posedge core_clk) begin
        cpu_irq_ack <= 1'b0;
        if (rst || !cpu_irq_req || cpu_irq_ack) begin
            wait_cnt <= 0;
        end else if (take_en && wait_cnt >= int'(delay)) begin
            // One take per offered vector
            cpu_irq_ack <= 1'b1;
            taken_vec <= cpu_irq_vector;
        end else begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule

// ### tb/ipm_top_tb.sv
// Self-checking bench of the posted-flag, mask and vector registers
`timescale 1ns/10ps
module ipm_top_tb;
    localparam logic [9:0] REGS [8] = '{10'h0DA, 10'h0DB, 10'h0DC, 10'h0DE, 10'h0DF, 10'h0E0,
        10'h0E1, 10'h0E2};
    localparam logic [9:0] MREG [3] = '{10'h0E0, 10'h0E1, 10'h0DF};
    localparam logic [7:0] TVAL [7] = '{8'hC3, 8'h5A, 8'h3F, 8'h80, 8'hFF, 8'hFF, 8'hFF};
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, gate, ack, req, take_en, se, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] pstrb, dly;
    logic [21:0] ev;
    logic [7:0] vec, tvec, last_v;
    logic [2:0][7:0] fl, mk;
    int errors, n_checks, seed, i, n_taken, want;

    ipm_top i_ipm_top (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_fail_event(ev[0]), .external_line_0(ev[1]),
        .spi_tx_event(ev[2]), .spi_rx_event(ev[3]), .gpio_port0_event(ev[4]),
        .external_line_1(ev[5]), .sleep_timer_event(ev[6]), .gpio_port1_event(ev[7]),
        .endpoint0_event(ev[8]), .endpoint1_event(ev[9]), .endpoint2_event(ev[10]),
        .usb_reset_event(ev[11]), .usb_active_event(ev[12]), .ms_timer_event(ev[13]),
        .interval_timer_event(ev[14]), .capture0_event(ev[15]), .capture1_event(ev[16]),
        .counter_wrap_event(ev[17]), .external_line_2(ev[18]), .ps2_data_low_event(ev[19]),
        .gpio_port2_event(ev[20]), .gpio_port3_event(ev[21]), .global_irq_gate(gate),
        .cpu_irq_ack(ack), .cpu_irq_req(req), .cpu_irq_vector(vec)
    );
    ipm_cpu_model i_ipm_cpu_model (
        .core_clk(core_clk), .rst(rst), .take_en(take_en), .delay(dly), .cpu_irq_req(req),
        .cpu_irq_vector(vec), .cpu_irq_ack(ack), .taken_vec(tvec)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ----
    // Helpers
    // ----
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] exp_vec(input logic [23:0] p);
        logic [4:0] b;
        b = 5'h1F;
        for (int k = 0; k < 22; k++) begin
            if (p[k] && ipm_pkg::SRC_PRIO[k] < b) b = ipm_pkg::SRC_PRIO[k];
        end
        return (b == 5'h1F) ? 8'h00 : {1'b0, b, 2'b00};
    endfunction

    // Events pulse only in the access cycle
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
        input logic [21:0] e = 22'h0, input logic [1:0] lo = 2'b00);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, lo};
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        ev <= e;
        @(posedge core_clk);
        while (pready !== 1'b1 && t < 20) begin
            t++;
            @(posedge core_clk);
        end
        if (t == 20) errors++;
        rv = prdata;
        err = pslverr;
        ev <= 22'h0;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [21:0] e = 22'h0);
        int j;
        j = idx - 10'h0DA;
        apb(1'b1, idx, d, e);
        case (idx)
            10'h0DE: se = d[7];
            10'h0DF: mk[2] = d & 8'h7F;
            10'h0E0: mk[0] = d;
            10'h0E1: mk[1] = d;
            10'h0E2: fl = fl & ~mk;
            default: if (j < 3) fl[j] = se ? fl[j] | d : fl[j] & d;
        endcase
        fl = (fl | 24'(e)) & 24'h3FFFFF;
    endtask

    task automatic chkall();
        for (int j = 0; j < 3; j++) begin
            apb(1'b0, REGS[j], 8'h00);
            chk("posted flags", rv, 32'(fl[j]));
            apb(1'b0, MREG[j], 8'h00);
            chk("source mask", rv, 32'(mk[j]));
        end
        apb(1'b0, 10'h0DE, 8'h00);
        chk("soft post control", rv, {24'h0, se, 7'h00});
        apb(1'b0, 10'h0E2, 8'h00);
        chk("vector register", rv, 32'(exp_vec(fl & mk)));
        chk("irq vector", vec, exp_vec(fl & mk));
        chk("irq request", req, gate && |(fl & mk));
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        if (ack === 1'b1) begin
            chk("take order", tvec > last_v, 1'b1);
            last_v = tvec;
            n_taken++;
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        test_done();
    end

    // ----
    // Scenarios
    // ----
    initial begin
        seed = 84868;
        errors = 0;
        n_checks = 0;
        n_taken = 0;
        rst = 1'b1;
        {psel, penable, pwrite, gate, take_en, se} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        ev = 22'h0;
        dly = 4'h0;
        fl = 24'h0;
        mk = 24'h0;
        last_v = 8'h00;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        chkall();
        apb(1'b0, 10'h0DD, 8'h00);
        chk("unmapped error", err, 1'b1);
        apb(1'b0, 10'h0DA, 8'h00, 22'h0, 2'b01);
        chk("unaligned error", err, 1'b1);
        chk("unaligned data", rv, 32'h0);
        apb(1'b1, 10'h0E0, 8'hFF, 22'h0, 2'b10);
        pstrb <= 4'hE;
        apb(1'b1, 10'h0E1, 8'hFF);
        pstrb <= 4'hF;
        chkall();
        for (i = 0; i < 22; i++) begin
            wr(10'h0DD, 8'h00, 22'(1) << i);
            chkall();
        end
        wr(10'h0DA, 8'hFF);
        wr(10'h0DE, 8'h80);
        wr(10'h0DB, 8'h00);
        chkall();
        wr(10'h0DE, 8'h00);
        wr(10'h0DA, 8'h5A, 22'h000001);
        chkall();
        for (i = 0; i < 60; i++) begin
            gate <= 1'($random(seed));
            wr(REGS[3'($random(seed))], 8'($random(seed)), 22'($random(seed)) & 22'h048201);
            chkall();
        end
        for (i = 0; i < 2; i++) begin
            for (int j = 6; j >= 0; j--) wr(REGS[j], TVAL[j]);
            gate <= 1'b1;
            want = n_taken + $countones(fl & mk);
            last_v = 8'h00;
            dly <= 4'(i * 3);
            take_en <= 1'b1;
            for (int t = 0; t < 800 && n_taken < want; t++) @(posedge core_clk);
            take_en <= 1'b0;
            chk("taken count", n_taken, want);
            fl = fl & ~mk;
            chkall();
        end
        wr(10'h0DE, 8'h80);
        wr(10'h0DA, 8'hFF);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        fl = 24'h0;
        mk = 24'h0;
        se = 1'b0;
        chkall();
        test_done();
    end
endmodule
